/* File: common/spw_params.svh */
// Constants for the port speed and width control block.
// Assumes inclusion by bare name from common/.
`ifndef SPW_PARAMS_SVH
`define SPW_PARAMS_SVH
// Register word offsets of the control end; SPW_OFF_RESET_CTL is not decoded there
`define SPW_OFF_PORT_CTL1   12'h000
`define SPW_OFF_LANE_CTL    12'h004
`define SPW_OFF_RESET_CTL   12'h008
`define SPW_OFF_STATUS      12'h00C
`define SPW_OFF_STRAP       12'h010
// Device reset control offset as seen through the link
`define SPW_DEV_RESET_CTL   24'hF20300
// Field positions
`define SPW_PORT_DISABLE_BIT_BIT    8
`define SPW_PWIDTH_LSB      0
`define SPW_DO_RESET_BIT    31
`define SPW_TX_RATE_LSB     0
`define SPW_RX_RATE_LSB     4
`define SPW_IDLE2_BIT       9
// Encodings
`define SPW_PWIDTH_1X       3'h2
`define SPW_SPD_ILLEGAL     3'h4
// Port reset duration
`define SPW_RESET_NS        40
`define SPW_RESET_CYC       ((`SPW_RESET_NS + 3) / 4)
`endif

/* File: common/spw_pkg.sv */
// Types shared by both ends of the speed and width control link.
// Assumes the params header is available.
package spw_pkg;
  typedef enum logic [2:0] {
    SPW_ST_IDLE    = 3'b000,
    SPW_ST_DISABLE = 3'b001,
    SPW_ST_LANES   = 3'b010,
    SPW_ST_RESET   = 3'b011,
    SPW_ST_WAITRST = 3'b100,
    SPW_ST_ENABLE  = 3'b101
  } spw_seq_t;
  typedef enum logic [1:0] {
    SPW_CMD_PORT_CTL = 2'h0,
    SPW_CMD_LANE_CTL = 2'h1,
    SPW_CMD_RESET    = 2'h2,
    SPW_CMD_NONE     = 2'h3
  } spw_cmd_t;
endpackage : spw_pkg

/* File: common/spw_link_if.sv */
// Configuration link between the controller and the switch port logic.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface spw_link_if #(parameter int PORTS = 4, parameter int LANES = 4);
  logic             wr_valid;
  spw_pkg::spw_cmd_t wr_cmd;
  logic [7:0]       wr_port;
  logic [1:0]       wr_lane;
  logic [31:0]      wr_data;
  logic             wr_ready;
  logic [PORTS-1:0] rst_busy;
  logic [9:0]       i2c_addr;
  logic             i2c_addr_ok;
  modport dev  (input  wr_valid, wr_cmd, wr_port, wr_lane, wr_data,
                output wr_ready, rst_busy, i2c_addr, i2c_addr_ok);
  modport ctrl (output wr_valid, wr_cmd, wr_port, wr_lane, wr_data,
                input  wr_ready, rst_busy, i2c_addr, i2c_addr_ok);
endinterface : spw_link_if

/* File: src/spw_dev.sv */
// Switch end: per port control, lane rates, port reset and straps.
// Assumes the link writes arrive synchronous to pclk.
//
// What this block and the controller end do
// (RQ1) No rate autonegotiation; rates set manually
// (RQ2) Speed straps global, per port override
// (RQ3) Port disable bit 8 stops traffic
// (RQ4) Lane registers hold TX and RX rates
// (RQ5) Reset control selects ports, trigger resets
// (RQ6) Controller: disable, rates, reset, enable
// (RQ7) Lane reversal only with IDLE2 partner
// (RQ8) Width override 010 forces single lane
// (RQ9) Test reset driven high by controller
// (RQ10) I2C address from ten straps, nonzero
// (RQ11) Speed straps sampled at reset; 100 illegal
// (RQ12) Reset trigger self clears when done
`timescale 1ns/10ps
`include "spw_params.svh"
module spw_dev #(
  parameter int PORTS = 4,
  parameter int LANES = 4
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  spw_link_if.dev                     lnk,
  input  wire logic [2:0]             speed_strap_pins,
  input  wire logic [9:0]             addr_strap_pins,
  input  wire logic [PORTS-1:0]       partner_idle2,
  output logic [PORTS-1:0]            port_active,
  output logic [PORTS-1:0]            port_in_reset,
  output logic [PORTS*LANES-1:0]      lane_enable,
  output logic [PORTS*LANES-1:0]      lane_reversed,
  output logic [PORTS*LANES*3-1:0]    lane_tx_rate,
  output logic [PORTS*LANES*3-1:0]    lane_rx_rate,
  output logic                        speed_illegal
);
  localparam int CW = $clog2(`SPW_RESET_CYC + 1);
  // ************************************************************
  // Strap capture
  // ************************************************************
  logic       strap_taken_r;
  logic [2:0] glob_spd_r;
  logic [9:0] i2c_addr_r;
  logic       addr_ok_r;
  // Straps latched on first clock after reset release
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      strap_taken_r <= 1'b0;
      glob_spd_r    <= 3'h0;
      i2c_addr_r    <= 10'h000;
      addr_ok_r     <= 1'b0;
      speed_illegal <= 1'b0;
    end
    else if (!strap_taken_r)
    begin
      strap_taken_r <= 1'b1;
      glob_spd_r    <= speed_strap_pins; // RQ2 RQ11
      i2c_addr_r    <= addr_strap_pins; // RQ10
      addr_ok_r     <= (addr_strap_pins != 10'h000); // RQ10
      speed_illegal <= (speed_strap_pins == `SPW_SPD_ILLEGAL); // RQ11
    end
  assign lnk.i2c_addr    = i2c_addr_r;
  // Address valid flag kept in a flop so the link sees a clean level
  assign lnk.i2c_addr_ok = addr_ok_r; // RQ10
  assign lnk.wr_ready    = strap_taken_r;
  // ************************************************************
  // Device reset control
  // ************************************************************
  logic [PORTS-1:0] port_sel_r;
  logic             do_reset_r;
  logic [CW-1:0]    rst_cnt_r;
  wire wr_rst = lnk.wr_valid && strap_taken_r &&
                lnk.wr_cmd == spw_pkg::SPW_CMD_RESET;
  // Trigger runs a fixed reset on selected ports then self clears
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      port_sel_r <= '0;
      do_reset_r <= 1'b0;
      rst_cnt_r  <= '0;
    end
    else if (do_reset_r)
    begin
      if (rst_cnt_r == CW'(1))
        do_reset_r <= 1'b0; // RQ12
      rst_cnt_r <= rst_cnt_r - CW'(1);
    end
    else if (wr_rst)
    begin
      port_sel_r <= lnk.wr_data[PORTS-1:0];
      if (lnk.wr_data[`SPW_DO_RESET_BIT])
      begin
        do_reset_r <= 1'b1; // RQ5
        rst_cnt_r  <= CW'(`SPW_RESET_CYC);
      end
    end
  wire [PORTS-1:0] rst_now = do_reset_r ? port_sel_r : '0;
  assign lnk.rst_busy = rst_now;
  // ************************************************************
  // Per port and per lane registers
  // ************************************************************
  genvar p, l;
  generate
    for (p = 0; p < PORTS; p++)
    begin : g_port
      logic        dis_r;
      logic [2:0]  width_r;
      logic        ovr_r;
      wire sel_p = lnk.wr_valid && strap_taken_r &&
                   lnk.wr_port == 8'(p);
      // Port control: disable bit, width override, speed override
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
          dis_r   <= 1'b0;
          width_r <= 3'h0;
          ovr_r   <= 1'b0;
        end
        else if (sel_p && lnk.wr_cmd == spw_pkg::SPW_CMD_PORT_CTL)
        begin
          dis_r   <= lnk.wr_data[`SPW_PORT_DISABLE_BIT_BIT]; // RQ3
          width_r <= lnk.wr_data[`SPW_PWIDTH_LSB +: 3]; // RQ8
        end
        else if (sel_p && lnk.wr_cmd == spw_pkg::SPW_CMD_LANE_CTL)
          ovr_r <= 1'b1; // RQ2
      // Port carries traffic only when enabled and out of reset
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
          port_active[p]   <= 1'b0;
          port_in_reset[p] <= 1'b0;
        end
        else
        begin
          port_active[p]   <= !dis_r && !rst_now[p] && strap_taken_r; // RQ3
          port_in_reset[p] <= rst_now[p]; // RQ5
        end
      for (l = 0; l < LANES; l++)
      begin : g_lane
        localparam int I = p * LANES + l;
        logic [2:0] tx_r;
        logic [2:0] rx_r;
        logic       set_r;
        // Lane rates: separate TX and RX fields, no autonegotiation
        always_ff @(posedge pclk or negedge presetn)
          if (!presetn)
          begin
            tx_r  <= 3'h0;
            rx_r  <= 3'h0;
            set_r <= 1'b0;
          end
          else if (sel_p && lnk.wr_cmd == spw_pkg::SPW_CMD_LANE_CTL &&
                   lnk.wr_lane == 2'(l))
          begin
            tx_r  <= lnk.wr_data[`SPW_TX_RATE_LSB +: 3]; // RQ4 RQ1
            rx_r  <= lnk.wr_data[`SPW_RX_RATE_LSB +: 3]; // RQ4 RQ1
            set_r <= 1'b1;
          end
        // Effective rate, lane use and reversal outputs
        always_ff @(posedge pclk or negedge presetn)
          if (!presetn)
          begin
            lane_tx_rate[I*3 +: 3]  <= 3'h0;
            lane_rx_rate[I*3 +: 3]  <= 3'h0;
            lane_enable[I]          <= 1'b0;
            lane_reversed[I]        <= 1'b0;
          end
          else
          begin
            lane_tx_rate[I*3 +: 3] <= (ovr_r && set_r) ? tx_r
                                                       : glob_spd_r; // RQ2
            lane_rx_rate[I*3 +: 3] <= (ovr_r && set_r) ? rx_r
                                                       : glob_spd_r; // RQ2
            lane_enable[I] <= port_active[p] &&
                              (l == 0 || width_r != `SPW_PWIDTH_1X); // RQ8
            lane_reversed[I] <= partner_idle2[p] && LANES > 1 &&
                                width_r != `SPW_PWIDTH_1X; // RQ7
          end
      end
    end
  endgenerate
endmodule : spw_dev

/* File: src/spw_ctrl.sv */
// Controller end: APB registers drive the speed change sequence.
// Assumes an APB master on pclk and the switch end on the link.
`timescale 1ns/10ps
`include "spw_params.svh"
module spw_ctrl #(
  parameter int LANES = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             jtag_trst,
  spw_link_if.ctrl         lnk
);
  logic [7:0]  port_r;
  logic [2:0]  width_r;
  logic [2:0]  tx_r;
  logic [2:0]  rx_r;
  logic        go_r;
  logic [1:0]  lane_r;
  spw_pkg::spw_seq_t st_r;
  wire acc = psel && penable;
  wire ok  = paddr == `SPW_OFF_PORT_CTL1 || paddr == `SPW_OFF_LANE_CTL ||
             paddr == `SPW_OFF_STATUS || paddr == `SPW_OFF_STRAP;
  // ************************************************************
  // APB registers
  // ************************************************************
  // One wait-free access; unmapped address gives pslverr
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      port_r <= 8'h00; width_r <= 3'h0; tx_r <= 3'h0; rx_r <= 3'h0;
      go_r <= 1'b0; prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
      jtag_trst <= 1'b0;
    end
    else
    begin
      jtag_trst <= 1'b1; // RQ9
      pready    <= psel && !penable;
      pslverr   <= psel && !penable && !ok;
      if (st_r == spw_pkg::SPW_ST_ENABLE && lnk.wr_ready)
        go_r <= 1'b0;
      if (acc && pwrite && paddr == `SPW_OFF_PORT_CTL1 && pready)
      begin
        port_r  <= pwdata[7:0];
        width_r <= pwdata[18:16];
      end
      if (acc && pwrite && paddr == `SPW_OFF_LANE_CTL && pready)
      begin
        tx_r <= pwdata[2:0];
        rx_r <= pwdata[6:4];
        go_r <= pwdata[31] || go_r;
      end
      if (psel && !penable)
        case (paddr)
          `SPW_OFF_PORT_CTL1: prdata <= {13'h0, width_r, 8'h0, port_r};
          `SPW_OFF_LANE_CTL:  prdata <= {go_r, 24'h0, rx_r, 1'b0, tx_r};
          `SPW_OFF_STATUS:    prdata <= {28'h0, 1'b0, st_r};
          `SPW_OFF_STRAP:     prdata <= {21'h0, lnk.i2c_addr_ok,
                                         lnk.i2c_addr};
          default:            prdata <= 32'h0;
        endcase
    end
  // ************************************************************
  // Speed change sequence
  // ************************************************************
  // Disable, write every lane, reset the port, re-enable
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_r   <= spw_pkg::SPW_ST_IDLE;
      lane_r <= 2'h0;
    end
    else if (lnk.wr_ready)
      case (st_r)
        spw_pkg::SPW_ST_IDLE:
          if (go_r && lnk.i2c_addr_ok) // RQ10
            st_r <= spw_pkg::SPW_ST_DISABLE;
        spw_pkg::SPW_ST_DISABLE:
        begin
          st_r   <= spw_pkg::SPW_ST_LANES; // RQ6
          lane_r <= 2'h0;
        end
        spw_pkg::SPW_ST_LANES:
          if (lane_r == 2'(LANES - 1))
            st_r <= spw_pkg::SPW_ST_RESET; // RQ6
          else
            lane_r <= lane_r + 2'h1;
        spw_pkg::SPW_ST_RESET:
          st_r <= spw_pkg::SPW_ST_WAITRST;
        spw_pkg::SPW_ST_WAITRST:
          if (lnk.rst_busy == '0)
            st_r <= spw_pkg::SPW_ST_ENABLE; // RQ6 RQ12
        spw_pkg::SPW_ST_ENABLE:
          st_r <= spw_pkg::SPW_ST_IDLE;
        default:
          st_r <= spw_pkg::SPW_ST_IDLE;
      endcase
  // Link write for the current sequence step
  always_comb
  begin
    lnk.wr_valid = 1'b1;
    lnk.wr_port  = port_r;
    lnk.wr_lane  = lane_r;
    lnk.wr_cmd   = spw_pkg::SPW_CMD_NONE;
    lnk.wr_data  = 32'h0;
    case (st_r)
      spw_pkg::SPW_ST_DISABLE:
      begin
        lnk.wr_cmd = spw_pkg::SPW_CMD_PORT_CTL;
        lnk.wr_data = 32'(1) << `SPW_PORT_DISABLE_BIT_BIT | 32'(width_r); // RQ6
      end
      spw_pkg::SPW_ST_LANES:
      begin
        lnk.wr_cmd  = spw_pkg::SPW_CMD_LANE_CTL; // RQ1
        lnk.wr_data = {25'h0, rx_r, 1'b0, tx_r};
      end
      spw_pkg::SPW_ST_RESET:
      begin
        lnk.wr_cmd  = spw_pkg::SPW_CMD_RESET;
        lnk.wr_data = (32'(1) << `SPW_DO_RESET_BIT) |
                      (32'(1) << port_r[4:0]);
      end
      spw_pkg::SPW_ST_ENABLE:
      begin
        lnk.wr_cmd  = spw_pkg::SPW_CMD_PORT_CTL;
        lnk.wr_data = 32'(width_r);
      end
      default:
        lnk.wr_valid = 1'b0;
    endcase
  end
endmodule : spw_ctrl

/* File: tb/spw_link_props.sv */
// Assertions on the configuration link between the two ends.
// Assumes one clock; link signals arrive as plain inputs.
`timescale 1ns/10ps
module spw_link_props #(
  parameter int PORTS = 4
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              wr_valid,
  input wire spw_pkg::spw_cmd_t wr_cmd,
  input wire logic [7:0]        wr_port,
  input wire logic [1:0]        wr_lane,
  input wire logic [31:0]       wr_data,
  input wire logic              wr_ready,
  input wire logic [PORTS-1:0]  rst_busy,
  input wire logic [9:0]        i2c_addr,
  input wire logic              i2c_addr_ok
);
  // ****************************************
  // Link rules
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_busy_bounded:
    assert property ($rose(|rst_busy) |-> ##[1:12] !(|rst_busy))
    else $error("port reset did not finish in time");
  a_reset_starts:
    assert property (wr_valid && wr_ready &&
      wr_cmd == spw_pkg::SPW_CMD_RESET |-> ##[1:2] (|rst_busy))
    else $error("reset command did not reset a port");
  a_disable_first:
    assert property (wr_valid && wr_cmd == spw_pkg::SPW_CMD_PORT_CTL &&
      wr_data[8] |=> wr_valid && wr_cmd == spw_pkg::SPW_CMD_LANE_CTL &&
      wr_lane == 2'h0)
    else $error("disable not followed by lane zero write");
  a_lane_walk:
    assert property (wr_valid && wr_cmd == spw_pkg::SPW_CMD_LANE_CTL &&
      wr_lane != 2'h3 |=> wr_valid && wr_lane == $past(wr_lane) + 2'h1)
    else $error("lane writes skipped a lane");
  a_lanes_then_rst:
    assert property (wr_valid && wr_cmd == spw_pkg::SPW_CMD_LANE_CTL |=>
      wr_valid && (wr_cmd == spw_pkg::SPW_CMD_LANE_CTL ||
      wr_cmd == spw_pkg::SPW_CMD_RESET))
    else $error("lane writes broken off");
  a_enable_after:
    assert property ($fell(|rst_busy) |-> ##[0:3] wr_valid &&
      wr_cmd == spw_pkg::SPW_CMD_PORT_CTL && !wr_data[8])
    else $error("port not enabled after reset");
  a_addr_valid:
    assert property (i2c_addr_ok == (i2c_addr != 10'h000))
    else $error("address flag disagrees with address");
  a_no_zero_addr:
    assert property (!i2c_addr_ok |-> !wr_valid)
    else $error("link write with zero address");
  a_ready_holds:
    assert property (wr_ready |=> wr_ready)
    else $error("link ready dropped");
endmodule : spw_link_props

/* File: tb/serial_port_speed_width_ctrl_tb.sv */
// Testbench: APB controller end joined to the switch end.
// Assumes the shared params header and package are compiled first.
`timescale 1ns/10ps
`include "spw_params.svh"
module serial_port_speed_width_ctrl_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic        pready, pslverr, jtag_trst, spd_bad, e;
  logic [2:0]  spd = 3'h3;
  logic [9:0]  adr = 10'h155;
  logic [3:0]  idle2 = 4'h5;
  logic [3:0]  act, inrst;
  logic [15:0] l_en, l_rev;
  logic [47:0] l_tx, l_rx;
  int          n_errors = 0;
  int          samples_checked = 0;
  bit          saw_dis, saw_rst;
  // ****************************************
  // Clock, ends and checker
  // ****************************************
  initial forever #2 pclk = ~pclk;
  spw_link_if #(.PORTS(4), .LANES(4)) lnk ();
  spw_ctrl i_spw_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .jtag_trst(jtag_trst), .lnk(lnk));
  spw_dev #(.PORTS(4), .LANES(4)) i_spw_dev (.pclk(pclk), .presetn(presetn),
    .lnk(lnk), .speed_strap_pins(spd), .addr_strap_pins(adr),
    .partner_idle2(idle2), .port_active(act), .port_in_reset(inrst),
    .lane_enable(l_en), .lane_reversed(l_rev), .lane_tx_rate(l_tx),
    .lane_rx_rate(l_rx), .speed_illegal(spd_bad));
  spw_link_props i_spw_link_props (.pclk(pclk),
    .presetn(presetn), .wr_valid(lnk.wr_valid), .wr_cmd(lnk.wr_cmd),
    .wr_port(lnk.wr_port), .wr_lane(lnk.wr_lane), .wr_data(lnk.wr_data),
    .wr_ready(lnk.wr_ready), .rst_busy(lnk.rst_busy),
    .i2c_addr(lnk.i2c_addr), .i2c_addr_ok(lnk.i2c_addr_ok));
  // ****************************************
  // Tasks
  // ****************************************
  // Report counts and verdict, then end the run
  task stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // Compare one value against its expectation
  task chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, waiting for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-raises psel in this step
    @(posedge pclk);
    if (n >= 50)
    begin
      n_errors++;
      stop_test;
    end
  endtask : apb
  // Reset both ends with the given straps
  task do_reset(input logic [2:0] s, input logic [9:0] a);
    presetn <= 1'b0;
    spd <= s;
    adr <= a;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset
  // Watch port 2 activity and all port resets while a speed change runs
  task watch(input int cyc);
    saw_dis = 1'b0;
    saw_rst = 1'b0;
    repeat (cyc)
    begin
      @(posedge pclk);
      if (act[2] === 1'b0) saw_dis = 1'b1;
      if (inrst !== 4'h0) saw_rst = 1'b1;
    end
  endtask : watch
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    do_reset(3'h3, 10'h155);
    chk(jtag_trst, 1'b1);
    chk(spd_bad, 1'b0);
    chk(act, 4'hF);
    chk(l_tx, {16{3'h3}});
    chk(l_rev, 16'h0F0F);
    apb(1'b0, `SPW_OFF_STRAP, 32'h0, q, e);
    chk(q, 32'h0000_0555);
    apb(1'b1, `SPW_OFF_RESET_CTL, 32'hFFFF_FFFF, q, e);
    chk(e, 1'b1);
    apb(1'b0, `SPW_OFF_RESET_CTL, 32'h0, q, e);
    chk({e, q}, {1'b1, 32'h0});
    // Speed change on port 2 with width forced to one lane
    apb(1'b1, `SPW_OFF_PORT_CTL1, 32'h0002_0002, q, e);
    apb(1'b1, `SPW_OFF_LANE_CTL, 32'h8000_0051, q, e);
    watch(40);
    chk(saw_dis, 1'b1);
    chk(saw_rst, 1'b1);
    apb(1'b0, `SPW_OFF_STATUS, 32'h0, q, e);
    chk(q, 32'h0);
    chk({act, inrst}, 8'hF0);
    chk(l_tx, {{4{3'h3}}, {4{3'h1}}, {8{3'h3}}});
    chk(l_rx, {{4{3'h3}}, {4{3'h5}}, {8{3'h3}}});
    chk(l_en, 16'hF1FF);
    chk(l_rev, 16'h000F);
    // Partner support moves to ports 1 and 3; port 2 stays forced 1x
    idle2 <= 4'hA;
    repeat (2) @(posedge pclk);
    chk(l_rev, 16'hF0F0);
    // Illegal speed strap is flagged; zero address blocks changes
    do_reset(3'h4, 10'h000);
    chk(spd_bad, 1'b1);
    apb(1'b0, `SPW_OFF_STRAP, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b1, `SPW_OFF_LANE_CTL, 32'h8000_0022, q, e);
    watch(20);
    chk(saw_rst, 1'b0);
    stop_test;
  end
endmodule : serial_port_speed_width_ctrl_tb
